/* File: inc/erfb_consts.vh */
`ifndef ERFB_CONSTS_VH
`define ERFB_CONSTS_VH
`define ERFB_START_MARK 8'h7E
`define ERFB_TYPE_CODE 8'h91
`define ERFB_FILLER_HI 8'hFF
`define ERFB_FILLER_LO 8'hFE
`define ERFB_CKSUM_BASE 8'hFF
`define ERFB_OPT_EXPLICIT_BIT 1
`define ERFB_HDR_LEN 16'h0012
`define ERFB_POS_TYPE 5'h03
`define ERFB_POS_ADDR 5'h04
`define ERFB_POS_RSVD 5'h0C
`define ERFB_POS_SRC_EP 5'h0E
`define ERFB_POS_DST_EP 5'h0F
`define ERFB_POS_CLUSTER 5'h10
`define ERFB_POS_PROFILE 5'h12
`define ERFB_POS_OPTS 5'h14
`define ERFB_OPT_ACK_BIT 0
`define ERFB_OPT_BCAST_BIT 1
`define ERFB_OPT_METH_LSB 6
`define ERFB_OPT_RSVD_MASK 8'h3C
`define ERFB_VEND_EP_LO 8'hDC
`define ERFB_VEND_EP_HI 8'hEE
`define ERFB_ADDR_OPTIONS 4'h0
`define ERFB_ADDR_STATUS 4'h1
`define ERFB_ADDR_FRAMES 4'h2
`define ERFB_ADDR_DROPS 4'h3
`define ERFB_OPTIONS_RST 8'h00
`endif

/* File: verilog/erfb_builder.v */
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "erfb_consts.vh"
module erfb_builder
(
    input wire clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire pkt_start,
    output reg pkt_start_ready,
    input wire [63:0] pkt_src_addr,
    input wire [7:0] pkt_src_ep,
    input wire [7:0] pkt_dst_ep,
    input wire [15:0] pkt_cluster,
    input wire [15:0] pkt_profile,
    input wire pkt_acked,
    input wire pkt_bcast,
    input wire [1:0] pkt_method,
    input wire [15:0] pkt_len,
    input wire [7:0] pl_data,
    input wire pl_valid,
    output reg pl_ready,
    output reg [7:0] out_data,
    output reg out_valid,
    output reg out_last,
    input wire out_ready
);

localparam S_IDLE = 5'b00001;
localparam S_HDR = 5'b00010;
localparam S_PAY = 5'b00100;
localparam S_SUM = 5'b01000;
localparam S_DROP = 5'b10000;

reg [4:0] state;
reg [7:0] api_output_options;
reg [7:0] frames;
reg [7:0] drops;
reg [63:0] f_addr;
reg [7:0] f_src_ep;
reg [7:0] f_dst_ep;
reg [15:0] f_cluster;
reg [15:0] f_profile;
reg [7:0] f_opts;
reg [15:0] f_len;
reg [15:0] pay_left;
reg [4:0] pos;
reg [7:0] sum;
// two-entry skid buffer between the byte builder and the output port
reg [7:0] buf_data [0:1];
reg [1:0] buf_last;
reg [1:0] buf_cnt;
reg rd_ptr;
reg wr_ptr;
reg [7:0] hdr_byte;
reg [7:0] push_data;
reg push_last;
reg push;
reg pop;
reg [7:0] opt_byte;
reg vend_ep;
wire buf_room;
wire [15:0] frame_len;

assign buf_room = (buf_cnt != 2'd2);
assign frame_len = `ERFB_HDR_LEN + f_len;

// the delivery method is only meaningful for vendor endpoints; others pass
// ack and broadcast only, delivery method reads as zero
always @*
begin
    vend_ep = (pkt_dst_ep >= `ERFB_VEND_EP_LO) &&
        (pkt_dst_ep <= `ERFB_VEND_EP_HI);
    opt_byte = 8'h00;
    opt_byte[`ERFB_OPT_ACK_BIT] = pkt_acked;
    opt_byte[`ERFB_OPT_BCAST_BIT] = pkt_bcast;
    if (vend_ep)
    begin
        opt_byte[`ERFB_OPT_METH_LSB+1:`ERFB_OPT_METH_LSB] =
            pkt_method;
    end
    opt_byte = opt_byte & ~`ERFB_OPT_RSVD_MASK;
end

always @*
begin
    hdr_byte = 8'h00;
    case (pos)
        5'h00: hdr_byte = `ERFB_START_MARK;
        5'h01: hdr_byte = frame_len[15:8];
        5'h02: hdr_byte = frame_len[7:0];
        `ERFB_POS_TYPE: hdr_byte = `ERFB_TYPE_CODE;
        5'h04: hdr_byte = f_addr[63:56];
        5'h05: hdr_byte = f_addr[55:48];
        5'h06: hdr_byte = f_addr[47:40];
        5'h07: hdr_byte = f_addr[39:32];
        5'h08: hdr_byte = f_addr[31:24];
        5'h09: hdr_byte = f_addr[23:16];
        5'h0A: hdr_byte = f_addr[15:8];
        5'h0B: hdr_byte = f_addr[7:0];
        `ERFB_POS_RSVD: hdr_byte = `ERFB_FILLER_HI;
        5'h0D: hdr_byte = `ERFB_FILLER_LO;
        `ERFB_POS_SRC_EP: hdr_byte = f_src_ep;
        `ERFB_POS_DST_EP: hdr_byte = f_dst_ep;
        `ERFB_POS_CLUSTER: hdr_byte = f_cluster[15:8];
        5'h11: hdr_byte = f_cluster[7:0];
        `ERFB_POS_PROFILE: hdr_byte = f_profile[15:8];
        5'h13: hdr_byte = f_profile[7:0];
        `ERFB_POS_OPTS: hdr_byte = f_opts;
        default: hdr_byte = 8'h00;
    endcase
end

always @*
begin
    push = 1'b0;
    push_data = 8'h00;
    push_last = 1'b0;
    pop = out_valid && out_ready;
    case (state)
        S_HDR:
        begin
            push = buf_room;
            push_data = hdr_byte;
        end
        S_PAY:
        begin
            push = pl_valid && pl_ready;
            push_data = pl_data;
        end
        S_SUM:
        begin
            push = buf_room;
            push_data = `ERFB_CKSUM_BASE - sum;
            push_last = 1'b1;
        end
        default:
        begin
            push = 1'b0;
        end
    endcase
end

always @(posedge clk)
begin
    if (srst)
    begin
        state <= S_IDLE;
        api_output_options <= `ERFB_OPTIONS_RST;
        frames <= 8'h00;
        drops <= 8'h00;
        f_addr <= 64'h0000000000000000;
        f_src_ep <= 8'h00;
        f_dst_ep <= 8'h00;
        f_cluster <= 16'h0000;
        f_profile <= 16'h0000;
        f_opts <= 8'h00;
        f_len <= 16'h0000;
        pay_left <= 16'h0000;
        pos <= 5'h00;
        sum <= 8'h00;
        pkt_start_ready <= 1'b0;
        pl_ready <= 1'b0;
        reg_rdata <= 8'h00;
    end
    else
    begin
        if (reg_wr && reg_addr == `ERFB_ADDR_OPTIONS)
        begin
            api_output_options <= reg_wdata;
        end
        if (reg_rd)
        begin
            if (reg_addr == `ERFB_ADDR_OPTIONS)
            begin
                reg_rdata <= api_output_options;
            end
            else if (reg_addr == `ERFB_ADDR_STATUS)
            begin
                reg_rdata <= {3'b000, state};
            end
            else if (reg_addr == `ERFB_ADDR_FRAMES)
            begin
                reg_rdata <= frames;
            end
            else if (reg_addr == `ERFB_ADDR_DROPS)
            begin
                reg_rdata <= drops;
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
        case (state)
            S_IDLE:
            begin
                pkt_start_ready <= 1'b1;
                pl_ready <= 1'b0;
                if (pkt_start && pkt_start_ready)
                begin
                    pkt_start_ready <= 1'b0;
                    f_addr <= pkt_src_addr;
                    f_src_ep <= pkt_src_ep;
                    f_dst_ep <= pkt_dst_ep;
                    f_cluster <= pkt_cluster;
                    f_profile <= pkt_profile;
                    f_opts <= opt_byte;
                    f_len <= pkt_len;
                    pay_left <= pkt_len;
                    pos <= 5'h00;
                    sum <= 8'h00;
                    // without the explicit bit the payload is consumed
                    // and discarded so the radio side never stalls
                    if (api_output_options[`ERFB_OPT_EXPLICIT_BIT])
                    begin
                        state <= S_HDR;
                    end
                    else
                    begin
                        drops <= drops + 8'h01;
                        state <= (pkt_len == 16'h0000) ? S_IDLE : S_DROP;
                        pl_ready <= (pkt_len != 16'h0000);
                    end
                end
            end
            S_HDR:
            begin
                if (push)
                begin
                    if (pos >= `ERFB_POS_TYPE)
                    begin
                        sum <= sum + hdr_byte;
                    end
                    pos <= pos + 5'h01;
                    if (pos == `ERFB_POS_OPTS)
                    begin
                        state <= (f_len == 16'h0000) ? S_SUM : S_PAY;
                        pl_ready <= 1'b0;
                    end
                end
            end
            S_PAY:
            begin
                // ready rises only when an entry is sure to be free
                pl_ready <= (buf_cnt == 2'd0) ||
                    (buf_cnt == 2'd1 && !push) || pop;
                if (push)
                begin
                    sum <= sum + pl_data;
                    pay_left <= pay_left - 16'h0001;
                    if (pay_left == 16'h0001)
                    begin
                        state <= S_SUM;
                        pl_ready <= 1'b0;
                    end
                end
            end
            S_SUM:
            begin
                if (push)
                begin
                    frames <= frames + 8'h01;
                    state <= S_IDLE;
                end
            end
            S_DROP:
            begin
                if (pl_valid && pl_ready)
                begin
                    pay_left <= pay_left - 16'h0001;
                    if (pay_left == 16'h0001)
                    begin
                        state <= S_IDLE;
                        pl_ready <= 1'b0;
                    end
                end
            end
            default:
            begin
                state <= S_IDLE;
            end
        endcase
    end
end

always @(posedge clk)
begin
    if (srst)
    begin
        buf_cnt <= 2'd0;
        rd_ptr <= 1'b0;
        wr_ptr <= 1'b0;
        buf_last <= 2'b00;
        buf_data[0] <= 8'h00;
        buf_data[1] <= 8'h00;
        out_data <= 8'h00;
        out_valid <= 1'b0;
        out_last <= 1'b0;
    end
    else
    begin
        if (push)
        begin
            buf_data[wr_ptr] <= push_data;
            buf_last[wr_ptr] <= push_last;
            wr_ptr <= ~wr_ptr;
        end
        if (pop)
        begin
            rd_ptr <= ~rd_ptr;
        end
        buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        // output register shows the head entry after every change
        if (pop)
        begin
            if (buf_cnt == 2'd2)
            begin
                out_data <= buf_data[~rd_ptr];
                out_last <= buf_last[~rd_ptr];
                out_valid <= 1'b1;
            end
            else if (push)
            begin
                out_data <= push_data;
                out_last <= push_last;
                out_valid <= 1'b1;
            end
            else
            begin
                out_valid <= 1'b0;
                out_last <= 1'b0;
            end
        end
        else if (!out_valid && push)
        begin
            out_data <= push_data;
            out_last <= push_last;
            out_valid <= 1'b1;
        end
    end
end

endmodule // erfb_builder

/* File: test/erfb_builder_chk.sv */
`timescale 1ns/1ns
`include "erfb_consts.vh"
module erfb_chk
(
    input wire clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire pkt_start,
    input wire pkt_start_ready,
    input wire [7:0] out_data,
    input wire out_valid,
    input wire out_last,
    input wire out_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    reg [15:0] pos;
    reg [15:0] len;
    reg [7:0] sum;
    reg [7:0] dep;
    reg [7:0] opt;
    reg en;
    wire xfer = out_valid && out_ready;
    always @(posedge clk)
    begin
        if (srst)
        begin
            pos <= 16'h0000;
            opt <= 8'h00;
        end
        else
        begin
            if (xfer)
                pos <= out_last ? 16'h0000 : pos + 16'h0001;
            if (reg_wr && reg_addr == 4'h0)
                opt <= reg_wdata;
        end
    end
    // frame fields captured so the trailer can be judged
    always @(posedge clk)
    begin
        if (xfer)
            sum <= (pos < 16'h0003) ? 8'h00 : sum + out_data;
        if (xfer && pos == 16'h0001)
            len[15:8] <= out_data;
        if (xfer && pos == 16'h0002)
            len[7:0] <= out_data;
        if (xfer && pos == 16'h000F)
            dep <= out_data;
        if (pkt_start && pkt_start_ready)
            en <= opt[1];
    end
    chk_start_mark: assert property (out_valid && pos == 16'h0000
        |-> out_data == `ERFB_START_MARK) else $error("bad start");
    chk_enable_gate: assert property (out_valid && pos == 16'h0000
        |-> en) else $error("frame while disabled");
    chk_type_code: assert property (out_valid && pos == 16'h0003
        |-> out_data == 8'h91) else $error("bad type");
    chk_filler_word: assert property (out_valid && pos[15:1] == 15'h0006
        |-> out_data == (pos[0] ? 8'hFE : 8'hFF)) else $error("bad filler");
    chk_opt_reserved: assert property (out_valid && pos == 16'h0014
        |-> (out_data & 8'h3C) == 8'h00) else $error("reserved set");
    chk_opt_method: assert property (out_valid && pos == 16'h0014
        && (dep < 8'hDC || dep > 8'hEE) |-> out_data[7:6] == 2'b00)
        else $error("method on plain ep");
    chk_frame_len: assert property (out_valid && out_last
        |-> pos == len + 16'h0003) else $error("bad length");
    chk_sum_byte: assert property (out_valid && out_last
        |-> out_data == 8'hFF - sum) else $error("bad checksum");
    chk_stall_hold: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data) && $stable(out_last))
        else $error("byte lost in stall");
    cover property (xfer && out_last);
    cover property (out_valid && !out_ready);
    cover property (xfer && pos == 16'h0014 && out_data[7:6] == 2'b11);
endmodule // erfb_chk
bind erfb_builder erfb_chk chk (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .pkt_start(pkt_start), .pkt_start_ready(pkt_start_ready),
    .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_ready(out_ready));

/* File: test/erfb_host.sv */
`timescale 1ns/1ns
module erfb_host
(
    input wire clk,
    input wire srst,
    input wire stall,
    input wire [7:0] out_data,
    input wire out_valid,
    output reg out_ready
);
    reg [1:0] phase;
    logic [7:0] q[$];
    // stalling two cycles of three keeps both buffer entries full
    always @(posedge clk)
    begin
        if (srst)
        begin
            phase <= 2'h0;
            out_ready <= 1'b0;
        end
        else
        begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            out_ready <= !stall || phase == 2'h2;
            if (out_valid && out_ready)
                q.push_back(out_data);
        end
    end
endmodule // erfb_host

/* File: test/erfb_builder_tb.sv */
`timescale 1ns/1ns
module erfb_builder_tb;
    reg clk, srst, reg_wr, reg_rd, pkt_start, pkt_acked, pkt_bcast;
    reg pl_valid, stall;
    reg [3:0] reg_addr;
    reg [7:0] reg_wdata, pkt_dst_ep, pl_data, pkt_src_ep;
    reg [63:0] pkt_src_addr;
    reg [15:0] pkt_cluster, pkt_profile;
    reg [1:0] pkt_method;
    reg [15:0] pkt_len;
    wire [7:0] reg_rdata, out_data;
    wire pkt_start_ready, pl_ready, out_valid, out_last, out_ready;
    integer miscompares, check_count, cycles;
    logic [7:0] exp[$];
    erfb_builder dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pkt_start(pkt_start),
        .pkt_start_ready(pkt_start_ready),
        .pkt_src_addr(pkt_src_addr), .pkt_src_ep(pkt_src_ep),
        .pkt_dst_ep(pkt_dst_ep), .pkt_cluster(pkt_cluster),
        .pkt_profile(pkt_profile), .pkt_acked(pkt_acked),
        .pkt_bcast(pkt_bcast), .pkt_method(pkt_method),
        .pkt_len(pkt_len), .pl_data(pl_data), .pl_valid(pl_valid),
        .pl_ready(pl_ready), .out_data(out_data), .out_valid(out_valid),
        .out_last(out_last), .out_ready(out_ready));
    erfb_host host (.clk(clk), .srst(srst), .stall(stall),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task wrap_up;
    begin
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            miscompares = miscompares + 1;
            wrap_up;
        end
    end
    task chk(input [7:0] got, input [7:0] want);
    begin
        check_count = check_count + 1;
        if (got !== want)
        begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    end
    endtask
    task wr(input [3:0] a, input [7:0] d);
    begin
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, input [7:0] want);
    begin
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        // data launched at the strobe edge is still held here
        @(posedge clk);
        chk(reg_rdata, want);
    end
    endtask
    task run_pkt(input [1:0] m, input [7:0] ep, input a, input b,
        input integer n, input en);
        integer i;
        reg [7:0] o, s;
        reg [167:0] h;
    begin
        o = {m, 4'h0, b, a};
        if (ep < 8'hDC || ep > 8'hEE)
            o[7:6] = 2'b00;
        // descriptor fields vary with the endpoint so a swapped byte shows
        h = {8'h7E, 16'h0012 + n[15:0], 8'h91, 56'h00112233445566, ep,
            16'hFFFE, ~ep, ep, 8'h12, ep, 8'hBE, 6'h3B, m, o};
        exp.delete();
        for (i = 20; i >= 0; i = i - 1)
            exp.push_back(h[i * 8 +: 8]);
        for (i = 0; i < n; i = i + 1)
            exp.push_back(8'hA0 + i[7:0]);
        s = 8'h00;
        for (i = 3; i < exp.size(); i = i + 1)
            s = s + exp[i];
        exp.push_back(8'hFF - s);
        host.q.delete();
        pkt_method <= m;
        pkt_dst_ep <= ep;
        pkt_src_addr <= {56'h00112233445566, ep};
        pkt_src_ep <= ~ep;
        pkt_cluster <= {8'h12, ep};
        pkt_profile <= {8'hBE, 6'h3B, m};
        pkt_acked <= a;
        pkt_bcast <= b;
        pkt_len <= n[15:0];
        pkt_start <= 1'b1;
        do @(posedge clk); while (pkt_start_ready !== 1'b1);
        pkt_start <= 1'b0;
        for (i = 0; i < n; i = i + 1)
        begin
            pl_data <= exp[21 + i];
            pl_valid <= 1'b1;
            do @(posedge clk); while (pl_ready !== 1'b1);
        end
        pl_valid <= 1'b0;
        if (!en)
            exp.delete();
        repeat (400)
            if (host.q.size() < exp.size() + 1 - en)
                @(posedge clk);
        chk(8'(host.q.size()), 8'(exp.size()));
        for (i = 0; i < exp.size(); i = i + 1)
            chk(host.q[i], exp[i]);
    end
    endtask
    task t_regs;
    begin
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h01);
        rd(4'hF, 8'h00);
        wr(4'h2, 8'h55);
        rd(4'h2, 8'h00);
    end
    endtask
    task t_drop;
    begin
        run_pkt(2'b11, 8'hE8, 1'b1, 1'b0, 3, 1'b0);
        rd(4'h3, 8'h01);
    end
    endtask
    task t_methods;
    begin
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h02);
        run_pkt(2'b01, 8'hDC, 1'b1, 1'b0, 6, 1'b1);
        run_pkt(2'b10, 8'hEE, 1'b0, 1'b1, 6, 1'b1);
        run_pkt(2'b11, 8'hE8, 1'b1, 1'b1, 6, 1'b1);
        run_pkt(2'b11, 8'hDB, 1'b1, 1'b0, 2, 1'b1);
        run_pkt(2'b10, 8'hEF, 1'b0, 1'b1, 1, 1'b1);
        rd(4'h2, 8'h05);
    end
    endtask
    task t_stall;
    begin
        stall <= 1'b1;
        run_pkt(2'b10, 8'hE0, 1'b1, 1'b1, 0, 1'b1);
        run_pkt(2'b01, 8'hE1, 1'b0, 1'b0, 12, 1'b1);
        stall <= 1'b0;
    end
    endtask
    initial
    begin
        miscompares = 0;
        check_count = 0;
        cycles = 0;
        srst = 1'b1;
        {reg_wr, reg_rd, pkt_start, pkt_acked, pkt_bcast} = 5'h00;
        {pl_valid, stall, reg_addr, reg_wdata, pl_data} = 22'h000000;
        {pkt_dst_ep, pkt_method, pkt_len} = 26'h0000000;
        {pkt_src_addr, pkt_src_ep, pkt_cluster, pkt_profile} = 104'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs;
        t_drop;
        t_methods;
        t_stall;
        wrap_up;
    end
endmodule // erfb_builder_tb
